// ==== src/sdpi_clk_out.sv ====
// SDRAM clock output stage: half-rate clock from the system clock.
// Assumes the parent holds rst_in synchronous to clk_sys_in.
module sdpi_clk_out (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    // Control
    input  wire logic interface_disable_bit_in,
    // Pin
    output logic      mem_clock_out,
    output logic      mem_clock_oe_n_out
);

    logic clk_lvl_ff;
    logic oe_n_ff;
    logic nxt_clk_lvl;
    logic nxt_oe_n;

    // ------------------------------------------------------------------
    // Clock generation
    // ------------------------------------------------------------------
    // Parked low and released while disabled, so the pin stops switching
    always_comb begin
        nxt_clk_lvl = sdpi_pkg::CLK_RESET_LVL;
        nxt_oe_n    = sdpi_pkg::OE_N_RELEASED;
        if (!interface_disable_bit_in) begin
            nxt_clk_lvl = ~clk_lvl_ff;
            nxt_oe_n    = sdpi_pkg::OE_N_DRIVING;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            clk_lvl_ff <= sdpi_pkg::CLK_RESET_LVL;
            oe_n_ff    <= sdpi_pkg::OE_N_RELEASED;
        end else begin
            clk_lvl_ff <= nxt_clk_lvl;
            oe_n_ff    <= nxt_oe_n;
        end
    end

    assign mem_clock_out      = clk_lvl_ff;
    assign mem_clock_oe_n_out = oe_n_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_clk_toggles;
        @(posedge clk_sys_in) disable iff (rst_in)
        !interface_disable_bit_in ##1 !interface_disable_bit_in
            |=> (mem_clock_out != $past(mem_clock_out)) && !mem_clock_oe_n_out;
    endproperty
    a_clk_toggles: assert property (p_clk_toggles)
        else $error("SDRAM clock not toggling while enabled");

    property p_clk_disabled;
        @(posedge clk_sys_in) disable iff (rst_in)
        interface_disable_bit_in |=> mem_clock_oe_n_out && !mem_clock_out;
    endproperty
    a_clk_disabled: assert property (p_clk_disabled)
        else $error("SDRAM clock still driven while disabled");

endmodule : sdpi_clk_out

// ==== src/sdpi_pins.sv ====
// SDRAM pin interface: registers the controller's command, address bit 10,
// clock enable, and a data mask set from the init phase, onto three-state pins.
// Assumes the SDRAM controller drives its inputs synchronous to clk_sys_in.

// What this block does
// - Row, column and write strobes encode the command; released in reset, high afterwards.
// - Clock enable pin follows the controller's clock enable level.
// - Dedicated bit-10 pin used during SDRAM accesses; general bit 10 stays free.
// - Mask high during a write cycle stops the SDRAM storing the data.
// - Mask high during a read cycle turns the SDRAM's data drivers off.
// - Mask high from reset release until initialization ends, then low always.
module sdpi_pins (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    // Controller command
    input  wire logic ctrl_row_strobe_in,
    input  wire logic ctrl_column_strobe_in,
    input  wire logic ctrl_write_enable_in,
    input  wire logic ctrl_clock_enable_in,
    input  wire logic ctrl_addr_bit10_in,
    input  wire logic sdram_access_in,
    input  wire logic init_done_in,
    // Other memory address bit 10
    input  wire logic general_addr_bit10_in,
    output logic      general_addr_bit10_out,
    // Software control
    input  wire logic interface_disable_bit_in,
    // SDRAM command pins
    output logic      row_strobe_out,
    output logic      column_strobe_out,
    output logic      mem_write_enable_out,
    output logic      mem_clock_enable_out,
    output logic      addr_bit10_out,
    output logic      data_mask_out,
    output logic      cmd_oe_n_out,
    // SDRAM clock pin
    output logic      mem_clock_out,
    output logic      mem_clock_oe_n_out,
    // Status
    output logic      init_done_out
);

    sdpi_pkg::sdpi_phase_e phase_ff;
    sdpi_pkg::sdpi_phase_e nxt_phase;
    logic                  ras_ff;
    logic                  cas_ff;
    logic                  we_ff;
    logic                  cke_ff;
    logic                  a10_ff;
    logic                  gen_a10_ff;
    logic                  mask_ff;
    logic                  oe_n_ff;
    logic                  nxt_ras;
    logic                  nxt_cas;
    logic                  nxt_we;
    logic                  nxt_cke;
    logic                  nxt_a10;
    logic                  nxt_gen_a10;
    logic                  nxt_mask;

    // ------------------------------------------------------------------
    // Phase tracking
    // ------------------------------------------------------------------
    always_comb begin
        nxt_phase = phase_ff;
        unique case (phase_ff)
            sdpi_pkg::PH_RESET: nxt_phase = sdpi_pkg::PH_INIT;
            sdpi_pkg::PH_INIT: begin
                if (init_done_in) begin
                    nxt_phase = sdpi_pkg::PH_RUN;
                end
            end
            sdpi_pkg::PH_RUN: nxt_phase = sdpi_pkg::PH_RUN;
            default: nxt_phase = sdpi_pkg::PH_RESET;
        endcase
    end

    // ------------------------------------------------------------------
    // Pin next values
    // ------------------------------------------------------------------
    // Disabled interface parks the command as a no-operation
    always_comb begin
        nxt_ras     = sdpi_pkg::CMD_IDLE_LVL;
        nxt_cas     = sdpi_pkg::CMD_IDLE_LVL;
        nxt_we      = sdpi_pkg::CMD_IDLE_LVL;
        nxt_cke     = ctrl_clock_enable_in;
        nxt_a10     = a10_ff;
        nxt_gen_a10 = gen_a10_ff;
        if (!interface_disable_bit_in && sdram_access_in) begin
            nxt_ras = ctrl_row_strobe_in;
            nxt_cas = ctrl_column_strobe_in;
            nxt_we  = ctrl_write_enable_in;
            nxt_a10 = ctrl_addr_bit10_in;
        end
        // General bit 10 holds during SDRAM cycles so refresh can overlap other accesses
        if (!sdram_access_in) begin
            nxt_gen_a10 = general_addr_bit10_in;
        end
        // Mask cannot follow accesses; the SDRAM sees it low for every cycle after init
        nxt_mask = (nxt_phase == sdpi_pkg::PH_RUN) ? sdpi_pkg::MASK_RUN_LVL
                                                   : sdpi_pkg::MASK_INIT_LVL;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            phase_ff   <= sdpi_pkg::PH_RESET;
            ras_ff     <= sdpi_pkg::CMD_IDLE_LVL;
            cas_ff     <= sdpi_pkg::CMD_IDLE_LVL;
            we_ff      <= sdpi_pkg::CMD_IDLE_LVL;
            cke_ff     <= sdpi_pkg::CKE_RESET_LVL;
            a10_ff     <= sdpi_pkg::A10_RESET_LVL;
            gen_a10_ff <= sdpi_pkg::A10_RESET_LVL;
            mask_ff    <= sdpi_pkg::MASK_INIT_LVL;
            oe_n_ff    <= sdpi_pkg::OE_N_RELEASED;
        end else begin
            phase_ff   <= nxt_phase;
            ras_ff     <= nxt_ras;
            cas_ff     <= nxt_cas;
            we_ff      <= nxt_we;
            cke_ff     <= nxt_cke;
            a10_ff     <= nxt_a10;
            gen_a10_ff <= nxt_gen_a10;
            mask_ff    <= nxt_mask;
            oe_n_ff    <= sdpi_pkg::OE_N_DRIVING;
        end
    end

    assign row_strobe_out         = ras_ff;
    assign column_strobe_out      = cas_ff;
    assign mem_write_enable_out   = we_ff;
    assign mem_clock_enable_out   = cke_ff;
    assign addr_bit10_out         = a10_ff;
    assign general_addr_bit10_out = gen_a10_ff;
    assign data_mask_out          = mask_ff;
    assign cmd_oe_n_out           = oe_n_ff;
    assign init_done_out          = (phase_ff == sdpi_pkg::PH_RUN);

    // ------------------------------------------------------------------
    // SDRAM clock
    // ------------------------------------------------------------------
    sdpi_clk_out u_clk_out (
        .clk_sys_in               (clk_sys_in),
        .rst_in                   (rst_in),
        .interface_disable_bit_in (interface_disable_bit_in),
        .mem_clock_out            (mem_clock_out),
        .mem_clock_oe_n_out       (mem_clock_oe_n_out)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_release_drive;
        @(posedge clk_sys_in) disable iff (rst_in)
        $fell(rst_in) |-> cmd_oe_n_out ##1 (!cmd_oe_n_out && row_strobe_out && data_mask_out);
    endproperty
    a_release_drive: assert property (p_release_drive)
        else $error("Pins not driven high after reset release");

    property p_cmd_follow;
        @(posedge clk_sys_in) disable iff (rst_in)
        (sdram_access_in && !interface_disable_bit_in)
            |=> row_strobe_out == $past(ctrl_row_strobe_in)
                && column_strobe_out == $past(ctrl_column_strobe_in)
                && mem_write_enable_out == $past(ctrl_write_enable_in);
    endproperty
    a_cmd_follow: assert property (p_cmd_follow)
        else $error("Command pins do not follow the controller");

    property p_cmd_idle;
        @(posedge clk_sys_in) disable iff (rst_in)
        !sdram_access_in |=> row_strobe_out && column_strobe_out && mem_write_enable_out;
    endproperty
    a_cmd_idle: assert property (p_cmd_idle)
        else $error("Command pins not idle outside SDRAM access");

    property p_cke_follow;
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 mem_clock_enable_out == $past(ctrl_clock_enable_in);
    endproperty
    a_cke_follow: assert property (p_cke_follow)
        else $error("Clock enable pin does not follow the controller");

    property p_a10_access;
        @(posedge clk_sys_in) disable iff (rst_in)
        (sdram_access_in && !interface_disable_bit_in)
            |=> addr_bit10_out == $past(ctrl_addr_bit10_in);
    endproperty
    a_a10_access: assert property (p_a10_access)
        else $error("Dedicated bit 10 wrong during SDRAM access");

    property p_gen_a10_hold;
        @(posedge clk_sys_in) disable iff (rst_in)
        sdram_access_in |=> $stable(general_addr_bit10_out);
    endproperty
    a_gen_a10_hold: assert property (p_gen_a10_hold)
        else $error("General bit 10 changed during SDRAM access");

    property p_mask_init;
        @(posedge clk_sys_in) disable iff (rst_in)
        (phase_ff != sdpi_pkg::PH_RUN) && !init_done_in |=> data_mask_out;
    endproperty
    a_mask_init: assert property (p_mask_init)
        else $error("Data mask low before initialization ends");

    property p_mask_run;
        @(posedge clk_sys_in) disable iff (rst_in)
        $rose(init_done_out) |-> !data_mask_out ##1 !data_mask_out ##1 !data_mask_out;
    endproperty
    a_mask_run: assert property (p_mask_run)
        else $error("Data mask not low after initialization");

    // A disabled interface must not issue commands even if the controller asks
    property p_cmd_disabled;
        @(posedge clk_sys_in) disable iff (rst_in)
        interface_disable_bit_in |=> row_strobe_out && column_strobe_out && mem_write_enable_out;
    endproperty
    a_cmd_disabled: assert property (p_cmd_disabled)
        else $error("Command pins not idle while interface disabled");

endmodule : sdpi_pins

// ==== src/sdpi_pkg.sv ====
// Constants shared by the SDRAM pin interface design files.
// Assumes nothing beyond a single system clock domain.
package sdpi_pkg;

    // ------------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------------
    localparam logic CMD_IDLE_LVL   = 1'h1;
    localparam logic OE_N_RELEASED  = 1'h1;
    localparam logic OE_N_DRIVING   = 1'h0;
    localparam logic MASK_INIT_LVL  = 1'h1;
    localparam logic MASK_RUN_LVL   = 1'h0;
    localparam logic A10_RESET_LVL  = 1'h1;
    localparam logic CKE_RESET_LVL  = 1'h1;
    localparam logic CLK_RESET_LVL  = 1'h0;

    // ------------------------------------------------------------------
    // Interface phases
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_RESET,
        PH_INIT,
        PH_RUN
    } sdpi_phase_e;

endpackage : sdpi_pkg

// ==== verification/sdpi_mem_model.sv ====
// Behavioural SDRAM at the far side of the pin interface.
// Assumes commands are sampled on the system clock edge.
module sdpi_mem_model (
    // Clock
    input  wire logic       clk_sys_in,
    // Pins from the interface
    input  wire logic       row_strobe_in,
    input  wire logic       column_strobe_in,
    input  wire logic       mem_write_enable_in,
    input  wire logic       mem_clock_enable_in,
    input  wire logic       data_mask_in,
    input  wire logic       cmd_oe_n_in,
    input  wire logic       mem_clock_in,
    input  wire logic       mem_clock_oe_n_in,
    // Resolved pin levels and status
    output logic            row_lvl_out,
    output logic            mask_lvl_out,
    output logic            clk_lvl_out,
    output logic            dq_drive_out,
    output logic [7:0]      n_stored_out,
    output logic [7:0]      n_masked_out
);
    // Released pins fall to their pull level, never the last value
    assign row_lvl_out  = cmd_oe_n_in ? 1'h1 : row_strobe_in;
    assign mask_lvl_out = cmd_oe_n_in ? 1'h1 : data_mask_in;
    assign clk_lvl_out  = mem_clock_oe_n_in ? 1'h0 : mem_clock_in;
    initial begin
        n_stored_out = 8'h00;
        n_masked_out = 8'h00;
        dq_drive_out = 1'h0;
    end
    always @(posedge clk_sys_in) begin
        dq_drive_out <= 1'h0;
        if (!cmd_oe_n_in && mem_clock_enable_in && row_strobe_in && !column_strobe_in) begin
            if (!mem_write_enable_in) begin
                if (mask_lvl_out) n_masked_out <= n_masked_out + 8'h01;
                else n_stored_out <= n_stored_out + 8'h01;
            end else begin
                dq_drive_out <= !mask_lvl_out;
            end
        end
    end
endmodule : sdpi_mem_model

// ==== verification/sdpi_pins_test.sv ====
// Self-checking bench for sdpi_pins with a behavioural SDRAM.
// Assumes the design and package are compiled first.
module sdpi_pins_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_in, rst_in, ras, cas, we, cke, a10, acc, idone, ga10, dis;
    wire logic ga10_o, ras_o, cas_o, we_o, cke_o, a10_o, dqm_o, oe_n, mclk, mclk_oe_n, idone_o;
    wire logic row_l, mask_l, clk_l, dq_drv;
    wire logic [7:0] n_st, n_mk;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    logic prev;
    sdpi_pins i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ctrl_row_strobe_in(ras),
        .ctrl_column_strobe_in(cas), .ctrl_write_enable_in(we), .ctrl_clock_enable_in(cke),
        .ctrl_addr_bit10_in(a10), .sdram_access_in(acc), .init_done_in(idone),
        .general_addr_bit10_in(ga10), .general_addr_bit10_out(ga10_o), .interface_disable_bit_in(dis),
        .row_strobe_out(ras_o), .column_strobe_out(cas_o), .mem_write_enable_out(we_o),
        .mem_clock_enable_out(cke_o), .addr_bit10_out(a10_o), .data_mask_out(dqm_o),
        .cmd_oe_n_out(oe_n), .mem_clock_out(mclk), .mem_clock_oe_n_out(mclk_oe_n), .init_done_out(idone_o));
    sdpi_mem_model i_mem (.clk_sys_in(clk_sys_in), .row_strobe_in(ras_o), .column_strobe_in(cas_o),
        .mem_write_enable_in(we_o), .mem_clock_enable_in(cke_o), .data_mask_in(dqm_o),
        .cmd_oe_n_in(oe_n), .mem_clock_in(mclk), .mem_clock_oe_n_in(mclk_oe_n), .row_lvl_out(row_l),
        .mask_lvl_out(mask_l), .clk_lvl_out(clk_l), .dq_drive_out(dq_drv), .n_stored_out(n_st),
        .n_masked_out(n_mk));
    initial begin
        clk_sys_in = 1'h0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : step
    task automatic cmd(input logic [2:0] c, input logic a);
        {ras, cas, we} = c;
        a10 = a;
        acc = 1'h1;
    endtask : cmd
    task automatic t_init;
        cmd(3'h4, 1'h0);
        step(2);
        chk(n_mk, 8'h01);
        chk(n_st, 8'h00);
        cmd(3'h5, 1'h0);
        step(2);
        chk(dq_drv, 1'h0);
        acc = 1'h0;
        idone = 1'h1;
        step(1);
        chk(idone_o, 1'h1);
        idone = 1'h0;
        for (int i = 0; i < 5; i++) begin
            chk(mask_l, 1'h0);
            step(1);
        end
        cmd(3'h4, 1'h0);
        step(2);
        chk(n_st, 8'h01);
        cmd(3'h5, 1'h0);
        step(2);
        chk(dq_drv, 1'h1);
        $display("test init done");
    endtask : t_init
    task automatic t_cmd;
        acc = 1'h0;
        ga10 = 1'h1;
        step(1);
        chk(ga10_o, 1'h1);
        ga10 = 1'h0;
        for (int i = 0; i < 8; i++) begin
            cmd(i[2:0], i[0] ^ i[1]);
            step(1);
            chk({ras_o, cas_o, we_o}, i[2:0]);
            chk(a10_o, i[0] ^ i[1]);
            chk(ga10_o, 1'h1);
        end
        acc = 1'h0;
        step(1);
        chk({ras_o, cas_o, we_o}, 3'h7);
        chk(a10_o, 1'h0);
        chk(ga10_o, 1'h0);
        cke = 1'h0;
        step(1);
        chk(cke_o, 1'h0);
        cke = 1'h1;
        step(1);
        chk(cke_o, 1'h1);
        $display("test command done");
    endtask : t_cmd
    task automatic t_clk;
        prev = clk_l;
        step(1);
        chk(clk_l, !prev);
        dis = 1'h1;
        cmd(3'h4, 1'h0);
        step(1);
        chk(mclk_oe_n, 1'h1);
        chk(clk_l, 1'h0);
        chk({ras_o, cas_o, we_o}, 3'h7);
        dis = 1'h0;
        acc = 1'h0;
        step(1);
        chk(mclk_oe_n, 1'h0);
        prev = clk_l;
        step(1);
        chk(clk_l, !prev);
        $display("test clock done");
    endtask : t_clk
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        {rst_in, ras, cas, we, cke, a10, acc, idone, ga10, dis} = 10'h3F0;
        step(3);
        chk(row_l, 1'h1);
        chk(oe_n, 1'h1);
        chk(clk_l, 1'h0);
        rst_in = 1'h0;
        step(1);
        chk(oe_n, 1'h0);
        chk(row_l, 1'h1);
        chk(mask_l, 1'h1);
        chk(mclk_oe_n, 1'h0);
        chk(idone_o, 1'h0);
        $display("test reset done");
        t_init();
        t_cmd();
        t_clk();
        test_done();
    end
endmodule : sdpi_pins_test
